// [rbp_host_model.sv]
// partner: instrument bus host writing the two ports
`default_nettype none
module rbp_host_model (
	input wire logic clk_i,
	output logic [7:0] bus_addr_o,
	output logic [7:0] bus_data_o,
	output logic data_valid_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		bus_addr_o = 8'h00;
		bus_data_o = 8'h00;
		data_valid_o = 1'b0;
	end
	// strobe high 4 clk, data held past the strobe fall, then lines released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		bus_addr_o = a;
		bus_data_o = d;
		data_valid_o = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 data_valid_o = 1'b0;
		@(posedge clk_i);
		#1;
		bus_addr_o = ~a; // released lines show the inverse
		bus_data_o = ~d;
		repeat (7) @(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// [rbp_interval_timer.sv]
// module: one-shot interval timer, busy for load cycles, done pulse at the end
`default_nettype none
module rbp_interval_timer (
	input wire logic clk_i,
	input wire logic nrst_i,
	rbp_tmr_if.tmr t
);
	logic [15:0] cnt_q;
	logic busy_q;
	logic done_q;

	// count down from one below the load value to zero; a start while busy retriggers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (t.start) begin
			cnt_q <= t.load - 16'h0001;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else if (busy_q && cnt_q == 16'h0000) begin
			busy_q <= 1'b0;
			done_q <= 1'b1;
		end else begin
			if (busy_q) begin
				cnt_q <= cnt_q - 16'h0001;
			end
			done_q <= 1'b0;
		end
	end

	assign t.busy = busy_q;
	assign t.done = done_q;
endmodule
`default_nettype wire

// [rbp_pkg.sv]
// package: port map, control fields and timing counts for the readout bus port
`default_nettype none
package rbp_pkg;
	// port addresses, upper address nibble decodes the port
	localparam logic [3:0] CTRL_PORT_NIB = 4'h5;
	localparam logic [3:0] ADDR_DATA_PORT_NIB = 4'h2;
	localparam logic [7:0] CTRL_PORT_ADDR = 8'h5F;
	localparam logic [7:0] ADDR_DATA_PORT_ADDR = 8'h2F;
	// control port fields
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_ADDR_MODE_BIT = 1;
	localparam int CTRL_PAGE1_BIT = 2;
	localparam int CTRL_MAX_SPAN_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// address/data port fields
	localparam int AD_CODE_MSB = 5;
	localparam int AD_VSHIFT_BIT = 6;
	localparam int AD_BLANK_BIT = 7;
	localparam logic [5:0] ADDR_LATCH_RESET = 6'h00;
	// timing, times in ns and derived clock counts
	localparam int CLK_PERIOD_NS = 5;
	localparam int OFF_TIME_NS = 175000;
	localparam int RETRACE_NS = 5900;
	localparam int UNBLANK_NS = 5000;
	localparam int OFF_CYCLES = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRACE_CYCLES = (RETRACE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNBLANK_CYCLES = UNBLANK_NS / CLK_PERIOD_NS;
	localparam int TMR_W = 16;
	// marker sequencer states
	typedef enum logic [2:0] {
		MK_IDLE = 3'b001,
		MK_RETRACE = 3'b010,
		MK_UNBLANK = 3'b100
	} rbp_mk_e;
endpackage
`default_nettype wire

// [rbp_readout_port.sv]
// module: readout bus port, character RAM loader, beam arbitration and marker dot
//
// Behaviour
// - control port decodes at upper nibble 5, address/data port at nibble 2
// - port select only while generator beam ownership low and strobe-valid high
// - addressed port captures bus data when strobe-valid falls; host holds data
// - only control bits 0-3 act; bit 0 switches character readout on or off
// - readout on: off-timer sets beam ownership, dot gate on, position addresses RAM
// - control bit 1 chooses address (1) or data (0) for address/data writes
// - address mode: no RAM write, bus isolated, address latched at strobe fall
// - data mode: address/data write strobes a RAM write with bus data
// - control bit 2 set picks normal page, clear picks 64-character message page
// - control bit 3 steers marker from tuning voltage, else marker centered
// - data bits 0-5 carry low RAM address or character code
// - data bit 6 moves upper row to mid-screen, lower row off screen
// - data bit 7 marks blank; keeps deflect-off high while ownership is held
// - marker dot refreshed right after upper readout row is scanned
// - marker starts on falling edge of row-done and drives marker-active low
// - during marker, vertical inputs 4 and 5 on, rows zero, horizontal selected
// - during marker, deflect-off driven low so amplifiers take marker signals
// - after about 5.9 us retrace, beam-on pulse of about 5 us draws dot
// - marker-active stays low until the unblank pulse has finished
// - readout off 175 us between characters, then ownership taken for next one
`default_nettype none
module rbp_readout_port #(
	parameter int OFF_CYC = rbp_pkg::OFF_CYCLES
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] bus_addr_i,
	input wire logic [7:0] bus_data_i,
	input wire logic data_valid_i,
	input wire logic char_done_i,
	input wire logic upper_row_done_n_i,
	input wire logic [5:0] position_i,
	input wire logic [7:0] ram_rdata_i,
	output logic [6:0] ram_addr_o,
	output logic [7:0] ram_wdata_o,
	output logic ram_we_o,
	output logic ram_bus_connect_o,
	output logic readout_on_o,
	output logic dot_gate_en_o,
	output logic generator_owns_beam_o,
	output logic readout_deflect_off_o,
	output logic marker_active_n_o,
	output logic readout_beam_on_o,
	output logic [1:0] marker_vert_o,
	output logic marker_horiz_tune_o,
	output logic vertical_shift_o
);
	// two-stage synchronisers for the bus, strobe, char-done and row-done pin inputs
	logic [7:0] addr_s1_q, addr_s2_q;
	logic [7:0] data_s1_q, data_s2_q;
	logic valid_s1_q, valid_s2_q, valid_d1_q;
	logic cdone_s1_q, cdone_s2_q, cdone_d1_q;
	logic top_s1_q, top_s2_q, top_d1_q;

	// port state
	logic [7:0] ctrl_q;
	logic [5:0] addr_latch_q;
	logic sel_ctrl_q, sel_data_q;
	logic [7:0] wdata_q;
	logic we_q;

	// beam arbitration and marker
	logic generator_owns_beam_q;
	logic off_armed_q;
	rbp_pkg::rbp_mk_e mk_q;

	logic valid_fall, cdone_rise, top_fall;
	logic decode_en;
	logic readout_on, addr_mode, page1, max_span;
	logic marker_on;

	rbp_tmr_if off_t ();
	rbp_tmr_if ret_t ();
	rbp_tmr_if unb_t ();

	rbp_interval_timer u_off (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.t(off_t)
	);
	rbp_interval_timer u_ret (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.t(ret_t)
	);
	rbp_interval_timer u_unb (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.t(unb_t)
	);

	// bring bus and scan pins into the clock domain
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_s1_q <= 8'h00;
			addr_s2_q <= 8'h00;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			valid_s1_q <= 1'b0;
			valid_s2_q <= 1'b0;
			cdone_s1_q <= 1'b0;
			cdone_s2_q <= 1'b0;
			top_s1_q <= 1'b1;
			top_s2_q <= 1'b1;
		end else begin
			addr_s1_q <= bus_addr_i;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= bus_data_i;
			data_s2_q <= data_s1_q;
			valid_s1_q <= data_valid_i;
			valid_s2_q <= valid_s1_q;
			cdone_s1_q <= char_done_i;
			cdone_s2_q <= cdone_s1_q;
			top_s1_q <= upper_row_done_n_i;
			top_s2_q <= top_s1_q;
		end
	end

	// edge history, read only from the second synchroniser stage
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			valid_d1_q <= 1'b0;
			cdone_d1_q <= 1'b0;
			top_d1_q <= 1'b1;
		end else begin
			valid_d1_q <= valid_s2_q;
			cdone_d1_q <= cdone_s2_q;
			top_d1_q <= top_s2_q;
		end
	end

	assign valid_fall = valid_d1_q && !valid_s2_q;
	assign cdone_rise = cdone_s2_q && !cdone_d1_q;
	assign top_fall = top_d1_q && !top_s2_q;

	// decoded control fields
	assign readout_on = ctrl_q[rbp_pkg::CTRL_ON_BIT];
	assign addr_mode = ctrl_q[rbp_pkg::CTRL_ADDR_MODE_BIT];
	assign page1 = ctrl_q[rbp_pkg::CTRL_PAGE1_BIT];
	assign max_span = ctrl_q[rbp_pkg::CTRL_MAX_SPAN_BIT];

	// decoder runs only with beam not owned and strobe-valid high
	assign decode_en = !generator_owns_beam_q && valid_s2_q;

	// remember which port the strobe addressed while it was valid
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sel_ctrl_q <= 1'b0;
			sel_data_q <= 1'b0;
		end else if (decode_en) begin
			sel_ctrl_q <= addr_s2_q[7:4] == rbp_pkg::CTRL_PORT_NIB;
			sel_data_q <= addr_s2_q[7:4] == rbp_pkg::ADDR_DATA_PORT_NIB;
		end else if (!valid_s2_q) begin
			sel_ctrl_q <= 1'b0;
			sel_data_q <= 1'b0;
		end
	end

	// bus data held at the last valid cycle, taken when the strobe falls
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wdata_q <= 8'h00;
		end else if (decode_en) begin
			wdata_q <= data_s2_q;
		end
	end

	// control port; upper four bits have no function and are kept zero
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ctrl_q <= rbp_pkg::CTRL_RESET;
		end else if (valid_fall && sel_ctrl_q) begin
			ctrl_q <= {4'h0, wdata_q[3:0]};
		end
	end

	// address latch loads only in address mode
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			addr_latch_q <= rbp_pkg::ADDR_LATCH_RESET;
		end else if (valid_fall && sel_data_q && addr_mode) begin
			addr_latch_q <= wdata_q[rbp_pkg::AD_CODE_MSB:0];
		end
	end

	// one-cycle RAM write strobe in data mode; host sequencing
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			we_q <= 1'b0;
		end else begin
			we_q <= valid_fall && sel_data_q && !addr_mode;
		end
	end

	// beam ownership: off-timer sets it, end of character clears it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			generator_owns_beam_q <= 1'b0;
		end else if (!readout_on || cdone_rise) begin
			generator_owns_beam_q <= 1'b0;
		end else if (off_t.done) begin
			generator_owns_beam_q <= 1'b1;
		end
	end

	// off-timer starts once, in the first cycle that readout is on and beam is not owned
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			off_armed_q <= 1'b0;
		end else if (!readout_on || generator_owns_beam_q) begin
			off_armed_q <= 1'b0;
		end else begin
			off_armed_q <= 1'b1;
		end
	end

	assign off_t.start = readout_on && !generator_owns_beam_q && !off_armed_q;
	assign off_t.load = 16'(OFF_CYC);

	// marker sequencer: retrace wait then unblank pulse
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mk_q <= rbp_pkg::MK_IDLE;
		end else begin
			case (mk_q)
				rbp_pkg::MK_IDLE: begin
					if (top_fall) begin
						mk_q <= rbp_pkg::MK_RETRACE;
					end
				end
				rbp_pkg::MK_RETRACE: begin
					if (ret_t.done) begin
						mk_q <= rbp_pkg::MK_UNBLANK;
					end
				end
				rbp_pkg::MK_UNBLANK: begin
					if (unb_t.done) begin
						mk_q <= rbp_pkg::MK_IDLE;
					end
				end
				default: begin
					mk_q <= rbp_pkg::MK_IDLE;
				end
			endcase
		end
	end

	assign ret_t.start = mk_q == rbp_pkg::MK_IDLE && top_fall;
	assign ret_t.load = 16'(rbp_pkg::RETRACE_CYCLES);
	assign unb_t.start = ret_t.done && mk_q == rbp_pkg::MK_RETRACE;
	assign unb_t.load = 16'(rbp_pkg::UNBLANK_CYCLES);

	assign marker_on = mk_q != rbp_pkg::MK_IDLE;

	// RAM address and write path
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ram_addr_o <= 7'h00;
			ram_wdata_o <= 8'h00;
		end else begin
			if (readout_on) begin
				ram_addr_o <= {page1, position_i};
			end else begin
				ram_addr_o <= {page1, addr_latch_q};
			end
			ram_wdata_o <= wdata_q;
		end
	end

	assign ram_we_o = we_q;
	assign ram_bus_connect_o = !addr_mode;

	// beam and marker outputs
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			readout_deflect_off_o <= 1'b1;
			marker_active_n_o <= 1'b1;
			readout_beam_on_o <= 1'b0;
			marker_vert_o <= 2'b00;
			marker_horiz_tune_o <= 1'b0;
			vertical_shift_o <= 1'b0;
		end else begin
			// blank characters keep the trace on the spectrum
			readout_deflect_off_o <= !(marker_on ||
				(generator_owns_beam_q && !ram_rdata_i[rbp_pkg::AD_BLANK_BIT]));
			marker_active_n_o <= !marker_on;
			readout_beam_on_o <= mk_q == rbp_pkg::MK_UNBLANK;
			marker_vert_o <= marker_on ? 2'b11 : 2'b00;
			marker_horiz_tune_o <= marker_on && max_span;
			vertical_shift_o <= ram_rdata_i[rbp_pkg::AD_VSHIFT_BIT];
		end
	end

	assign readout_on_o = readout_on;
	assign dot_gate_en_o = readout_on && generator_owns_beam_q;
	assign generator_owns_beam_o = generator_owns_beam_q;
endmodule
`default_nettype wire

// [rbp_readout_port_checker.sv]
// checker: concurrent assertions on the readout bus port outputs
`default_nettype none
module rbp_readout_port_checker #(
	parameter int OFF_CYC = 50
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic upper_row_done_n_i,
	input wire logic ram_bus_connect_o,
	input wire logic readout_on_o,
	input wire logic dot_gate_en_o,
	input wire logic generator_owns_beam_o,
	input wire logic readout_deflect_off_o,
	input wire logic marker_active_n_o,
	input wire logic readout_beam_on_o,
	input wire logic [1:0] marker_vert_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int ret_q;
	int unb_q;
	int off_q;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// marker low cycles before unblank
	always_ff @(posedge clk_i) begin
		if (marker_active_n_o || readout_beam_on_o) ret_q <= 0;
		else ret_q <= ret_q + 1;
	end
	// unblank length
	always_ff @(posedge clk_i) begin
		if (!readout_beam_on_o) unb_q <= 0;
		else unb_q <= unb_q + 1;
	end
	// off-time while readout is on and beam not owned
	always_ff @(posedge clk_i) begin
		if (!readout_on_o || generator_owns_beam_o) off_q <= 0;
		else off_q <= off_q + 1;
	end
	dot_gate_a: assert property (dot_gate_en_o == (readout_on_o && generator_owns_beam_o))
		else $error("dot gate wrong");
	reset_val_a: assert property (!$past(nrst_i) |-> !readout_on_o && ram_bus_connect_o)
		else $error("reset values wrong");
	mk_start_a: assert property ($fell(upper_row_done_n_i) |-> ##[1:6] !marker_active_n_o)
		else $error("marker did not start");
	mk_drive_a: assert property (!marker_active_n_o && !$past(marker_active_n_o) |->
		!readout_deflect_off_o && marker_vert_o == 2'b11) else $error("marker drive wrong");
	beam_hold_a: assert property (readout_beam_on_o |-> !marker_active_n_o)
		else $error("marker ended early");
	retrace_len_a: assert property ($rose(readout_beam_on_o) |-> ret_q >= 1176 && ret_q <= 1186)
		else $error("retrace length wrong");
	unblank_len_a: assert property ($fell(readout_beam_on_o) |-> unb_q >= 996 && unb_q <= 1004)
		else $error("unblank length wrong");
	off_time_a: assert property ($rose(generator_owns_beam_o) |->
		off_q >= OFF_CYC - 4 && off_q <= OFF_CYC + 6) else $error("off time wrong");
endmodule
bind rbp_readout_port rbp_readout_port_checker #(.OFF_CYC(OFF_CYC)) u_chk (.clk_i(clk_i),
	.nrst_i(nrst_i), .upper_row_done_n_i(upper_row_done_n_i),
	.ram_bus_connect_o(ram_bus_connect_o), .readout_on_o(readout_on_o),
	.dot_gate_en_o(dot_gate_en_o), .generator_owns_beam_o(generator_owns_beam_o),
	.readout_deflect_off_o(readout_deflect_off_o), .marker_active_n_o(marker_active_n_o),
	.readout_beam_on_o(readout_beam_on_o), .marker_vert_o(marker_vert_o));
`default_nettype wire

// [rbp_readout_port_tb.sv]
// testbench: host writes, beam ownership and marker against a bench model
`default_nettype none
`define CHK(nm, e, s) begin \
	checked++; \
	if ((s) !== (e)) begin \
		err_total++; \
		$display("CHECK FAILED %s exp %0h got %0h", nm, e, s); \
	end \
end
module rbp_readout_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OFF_T = 50;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic char_done_i = 1'b0;
	logic upper_row_done_n_i = 1'b1;
	logic [5:0] position_i = 6'h00;
	logic [7:0] ram_rdata_i = 8'h00;
	logic [7:0] bus_addr, bus_data, wdata, r;
	logic dv, we, conn, ron, gate, own_o, defl, mkn, beam, horiz, vsh;
	logic [6:0] raddr;
	logic [1:0] vert;
	logic [14:0] q[$];
	logic [14:0] e_w;
	int err_total, checked, cyc, ctrl, lat, own, i;
	rbp_host_model u_rbp_host_model (.clk_i(clk_i), .bus_addr_o(bus_addr), .bus_data_o(bus_data),
		.data_valid_o(dv));
	rbp_readout_port #(.OFF_CYC(OFF_T)) u_rbp_readout_port (.clk_i(clk_i), .nrst_i(nrst_i),
		.bus_addr_i(bus_addr), .bus_data_i(bus_data), .data_valid_i(dv),
		.char_done_i(char_done_i), .upper_row_done_n_i(upper_row_done_n_i),
		.position_i(position_i), .ram_rdata_i(ram_rdata_i), .ram_addr_o(raddr),
		.ram_wdata_o(wdata), .ram_we_o(we), .ram_bus_connect_o(conn), .readout_on_o(ron),
		.dot_gate_en_o(gate), .generator_owns_beam_o(own_o), .readout_deflect_off_o(defl),
		.marker_active_n_o(mkn), .readout_beam_on_o(beam), .marker_vert_o(vert),
		.marker_horiz_tune_o(horiz), .vertical_shift_o(vsh));
	initial forever #2.5 clk_i = ~clk_i;
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// model update, bus write, then visible checks
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		if (own == 0 && a[7:4] == 4'h5) ctrl = int'(d & 8'h0F);
		else if (own == 0 && a[7:4] == 4'h2 && ctrl[1]) lat = int'(d[5:0]);
		else if (own == 0 && a[7:4] == 4'h2) q.push_back({ctrl[2], 6'(lat), d});
		u_rbp_host_model.wr(a, d);
		`CHK("on", ctrl[0], ron)
		`CHK("conn", !ctrl[1], conn)
		if (!ctrl[0]) `CHK("addr", {ctrl[2], 6'(lat)}, raddr)
	endtask
	// write pulses against queued model writes, and the run limit
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
		if (we === 1'b1 && q.size() == 0) `CHK("we", 1'b0, we)
		else if (we === 1'b1) begin
			e_w = q.pop_front();
			`CHK("write", e_w, {raddr, wdata})
		end
	end
	initial begin
		void'($urandom(69));
		repeat (6) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		@(posedge clk_i);
		#1 `CHK("rst_on", 1'b0, ron)
		`CHK("rst_mk", 1'b1, mkn)
		$display("test reset done");
		// character loads on both pages, a stray address after each
		for (i = 0; i < 12; i++) begin
			r = 8'($urandom);
			put(8'h5F, {r[7:4], 1'b0, i[0], 2'b10});
			put(8'h2F, r);
			put(8'h5F, {5'h00, i[0], 2'b00});
			put(8'h2F, 8'($urandom));
			put({4'($urandom_range(15, 6)), 4'hF}, r);
		end
		$display("test load done");
		// readout on, off-timer hands over the beam
		position_i = 6'($urandom);
		ram_rdata_i = 8'h80;
		put(8'h5F, 8'h05);
		`CHK("pos", {1'b1, position_i}, raddr)
		for (i = 0; i < OFF_T + 20 && own_o !== 1'b1; i++) @(posedge clk_i);
		#1 `CHK("own", 1'b1, own_o)
		`CHK("gate", 1'b1, gate)
		`CHK("blank", 1'b1, defl)
		ram_rdata_i = 8'h40;
		repeat (3) @(posedge clk_i);
		#1 `CHK("defl", 1'b0, defl)
		`CHK("vsh", 1'b1, vsh)
		own = 1;
		put(8'h5F, 8'h00);
		own = 0;
		char_done_i = 1'b1;
		repeat (4) @(posedge clk_i);
		#1 char_done_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#1 put(8'h5F, 8'h00);
		`CHK("own_clr", 1'b0, own_o)
		$display("test readout done");
		// marker centred, then steered by tuning voltage
		for (i = 0; i < 2; i++) begin
			put(8'h5F, {4'h0, i[0], 3'h0});
			upper_row_done_n_i = 1'b0;
			repeat (6) @(posedge clk_i);
			#1 `CHK("mk", 1'b0, mkn)
			`CHK("horiz", i[0], horiz)
			`CHK("vert", 2'b11, vert)
			`CHK("mk_defl", 1'b0, defl)
			upper_row_done_n_i = 1'b1;
			repeat (1250) @(posedge clk_i);
			#1 `CHK("beam", 1'b1, beam)
			repeat (1100) @(posedge clk_i);
			#1 `CHK("beam_off", 1'b0, beam)
			`CHK("mk_end", 1'b1, mkn)
		end
		$display("test marker done");
		`CHK("queue", 0, q.size())
		wrap_up();
	end
endmodule
`default_nettype wire

// [rbp_tmr_if.sv]
// interface: start/load/done group between the sequencer and one interval timer
`default_nettype none
interface rbp_tmr_if;
	logic start;
	logic [15:0] load;
	logic busy;
	logic done;
	modport ctl (output start, output load, input busy, input done);
	modport tmr (input start, input load, output busy, output done);
endinterface
`default_nettype wire
